// ### hw/cfg_upper_regs.sv
// upper configuration header registers: subsystem ident, rom base,
// capability pointer, latency/grant/interrupt.
// assumes a single clock, PCI reset as RSTN, one-cycle write strobes
// from the PCI config side and the processor side, EEPROM loader outside.
`timescale 1ns/1ps
module cfg_upper_regs (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // straps and rom sizing
  input  wire logic        ID_LOAD_ENABLE_PIN,
  input  wire logic [2:0]  BLOCK_SIZE_FIELD,
  // EEPROM loader
  input  wire logic        EE_LOAD_BUSY,
  input  wire logic        EE_LOAD_DONE,
  input  wire logic [15:0] EE_SUBSYSTEM_IDENT,
  input  wire logic [15:0] EE_SUBSYSTEM_VENDOR_IDENT,
  input  wire logic        EE_ROM_ENABLE,
  input  wire logic        EE_INT_PIN,
  input  wire logic [7:0]  EE_MIN_GNT,
  input  wire logic [7:0]  EE_MAX_LATENCY,
  // PCI configuration access
  input  wire logic        PCI_WR,
  input  wire logic [7:0]  PCI_ADDR,
  input  wire logic [31:0] PCI_WDATA,
  input  wire logic [3:0]  PCI_BE,
  output logic [31:0]      PCI_RDATA,
  // processor side bus access
  input  wire logic        PROC_WR,
  input  wire logic [7:0]  PROC_ADDR,
  input  wire logic [31:0] PROC_WDATA,
  input  wire logic [3:0]  PROC_BE,
  output logic [31:0]      PROC_RDATA,
  // decode and status
  input  wire logic [31:0] PCI_AD,
  output logic             ROM_HIT,
  output logic             ROM_REG_ENABLED,
  output logic             USES_INTA
);
  // ==========================================================
  // state
  logic        strap_r;
  logic        strap_taken_r;
  logic        rom_ok_r;
  logic [31:0] sid_r;
  logic [15:0] rom_ba_r;
  logic        rom_en_r;
  logic        int_pin_r;
  logic [7:0]  int_line_r;
  logic [7:0]  min_gnt_r;
  logic [7:0]  max_latency_field_r;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0]  a,
                                            input logic [31:0] subsystem_ident,
                                            input logic [31:0] rom,
                                            input logic [31:0] misc);
    if (a == cfg_upper_pkg::SUBSYS_ID_OFFS) begin
      read_word = subsystem_ident;
    end else if (a == cfg_upper_pkg::ROM_BASE_OFFS) begin
      read_word = rom;
    end else if (a == cfg_upper_pkg::CAP_PTR_OFFS) begin
      read_word = {24'h000000, cfg_upper_pkg::CAP_PTR_VALUE};
    end else if (a == cfg_upper_pkg::LAT_GNT_OFFS) begin
      read_word = misc;
    end else begin
      read_word = 32'h0000_0000;
    end
  endfunction

  // ==========================================================
  // rom base writable mask
  // block size mask
  wire [15:0] ba_mask   = 16'hFFFF << BLOCK_SIZE_FIELD;
  wire        rom_on    = rom_ok_r;

  wire [31:0] rom_word  = rom_on ?
                          {rom_ba_r & ba_mask, 15'h0000, rom_en_r} : 32'h0000_0000;
  wire [31:0] misc_word = {max_latency_field_r, min_gnt_r, 7'h00, int_pin_r, int_line_r};

  wire pci_rom  = PCI_WR  && PCI_ADDR  == cfg_upper_pkg::ROM_BASE_OFFS;
  wire proc_rom = PROC_WR && PROC_ADDR == cfg_upper_pkg::ROM_BASE_OFFS;
  wire proc_sid = PROC_WR && PROC_ADDR == cfg_upper_pkg::SUBSYS_ID_OFFS;
  wire proc_lg  = PROC_WR && PROC_ADDR == cfg_upper_pkg::LAT_GNT_OFFS;
  wire pci_lg   = PCI_WR  && PCI_ADDR  == cfg_upper_pkg::LAT_GNT_OFFS;

  // both buses, blocked during load; processor wins a tie
  wire        rom_wr    = rom_on && !EE_LOAD_BUSY && (pci_rom || proc_rom);
  wire [31:0] rom_src   = proc_rom ? merge(rom_word, PROC_WDATA, PROC_BE)
                                   : merge(rom_word, PCI_WDATA, PCI_BE);
  wire [15:0] ba_nxt    = (rom_ba_r & ~ba_mask) | (rom_src[31:16] & ba_mask);

  wire [31:0] sid_nxt   = merge(sid_r, PROC_WDATA, PROC_BE);
  wire [31:0] misc_proc = merge(misc_word, PROC_WDATA, PROC_BE);
  wire [31:0] misc_pci  = merge(misc_word, PCI_WDATA, PCI_BE);

  // ==========================================================
  // strap capture at release of reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_r       <= 1'b0;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_r       <= ID_LOAD_ENABLE_PIN;
      strap_taken_r <= 1'b1;
    end
  end

  // ==========================================================
  // subsystem identification
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sid_r <= cfg_upper_pkg::RESET_WORD;
    end else if (EE_LOAD_DONE && strap_r) begin
      sid_r <= {EE_SUBSYSTEM_IDENT, EE_SUBSYSTEM_VENDOR_IDENT};
    end else if (proc_sid && !EE_LOAD_BUSY) begin
      sid_r <= sid_nxt;
    end
  end

  // ==========================================================
  // expansion rom base
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rom_ok_r <= 1'b0;
      rom_ba_r <= 16'h0000;
      rom_en_r <= 1'b0;
    end else if (EE_LOAD_DONE && strap_r) begin
      rom_ok_r <= EE_ROM_ENABLE;
    end else if (rom_wr) begin
      rom_ba_r <= ba_nxt;
      rom_en_r <= rom_src[cfg_upper_pkg::ROM_EN_BIT];
    end
  end

  // ==========================================================
  // latency, grant, interrupt pin and line
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      int_pin_r  <= 1'b0;
      int_line_r <= 8'h00;
      min_gnt_r  <= 8'h00;
      max_latency_field_r  <= 8'h00;
    end else if (EE_LOAD_DONE && strap_r) begin
      int_pin_r <= EE_INT_PIN;
      min_gnt_r <= EE_MIN_GNT;
      max_latency_field_r <= EE_MAX_LATENCY;
    end else if (proc_lg && !EE_LOAD_BUSY) begin
      int_pin_r  <= misc_proc[cfg_upper_pkg::INT_PIN_LSB];
      int_line_r <= misc_proc[cfg_upper_pkg::INT_LINE_LSB +: 8];
      min_gnt_r  <= misc_proc[cfg_upper_pkg::MIN_GNT_LSB +: 8];
      max_latency_field_r  <= misc_proc[cfg_upper_pkg::MAX_LATENCY_FIELD_LSB +: 8];
    end else if (pci_lg) begin
      int_line_r <= misc_pci[cfg_upper_pkg::INT_LINE_LSB +: 8];
    end
  end

  // ==========================================================
  // read data and decode
  // fixed capability pointer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PCI_RDATA  <= 32'h0000_0000;
      PROC_RDATA <= 32'h0000_0000;
    end else begin
      PCI_RDATA  <= read_word(PCI_ADDR, sid_r, rom_word, misc_word);
      PROC_RDATA <= read_word(PROC_ADDR, sid_r, rom_word, misc_word);
    end
  end

  assign ROM_HIT         = rom_on && rom_en_r &&
                           ((PCI_AD[31:16] & ba_mask) == (rom_ba_r & ba_mask));
  assign ROM_REG_ENABLED = rom_on;
  assign USES_INTA       = int_pin_r;
endmodule

// ### hw/cfg_upper_pkg.sv
// constants for the upper configuration header register bank
// assumes word aligned register offsets as printed (byte addresses)
package cfg_upper_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] SUBSYS_ID_OFFS = 8'h2C;
  localparam logic [7:0] ROM_BASE_OFFS  = 8'h30;
  localparam logic [7:0] CAP_PTR_OFFS   = 8'h34;
  localparam logic [7:0] LAT_GNT_OFFS   = 8'h3C;
  // ==========================================================
  // field positions and values
  localparam int         ROM_BA_LSB      = 16;
  localparam int         ROM_EN_BIT      = 0;
  localparam logic [7:0] CAP_PTR_VALUE   = 8'hDC;
  localparam int         INT_PIN_LSB     = 8;
  localparam int         INT_LINE_LSB    = 0;
  localparam int         MIN_GNT_LSB     = 16;
  localparam int         MAX_LATENCY_FIELD_LSB     = 24;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
endpackage

// ### tb/cfg_upper_regs_sva.sv
// checker for the upper config header bank
// bound onto cfg_upper_regs, sees its ports only
`timescale 1ns/1ps
module cfg_upper_regs_sva (
  input wire logic        CLK, RSTN, PCI_WR, PROC_WR, EE_LOAD_BUSY, EE_LOAD_DONE,
  input wire logic        ROM_HIT, ROM_REG_ENABLED, USES_INTA,
  input wire logic [2:0]  BLOCK_SIZE_FIELD,
  input wire logic [3:0]  PROC_BE,
  input wire logic [7:0]  PCI_ADDR, PROC_ADDR,
  input wire logic [31:0] PCI_RDATA, PROC_RDATA, PROC_WDATA);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ==========
  // bits that must read zero at the rom base
  logic [31:0] ro_mask;
  assign ro_mask = (32'h1 << (5'h10 + BLOCK_SIZE_FIELD)) - 32'h2;
  property p_cap; PCI_ADDR == 8'h34 |=> PCI_RDATA == 32'h0000_00DC; endproperty
  a_cap: assert property (p_cap) else $error("capability word wrong");
  property p_sid_pci; PCI_WR && PCI_ADDR == 8'h2C && PROC_ADDR == 8'h2C && !PROC_WR &&
    !EE_LOAD_DONE ##1 PROC_ADDR == 8'h2C && !PROC_WR && !EE_LOAD_DONE |=>
    $stable(PROC_RDATA); endproperty
  a_sid_pci: assert property (p_sid_pci) else $error("ident changed by pci");
  property p_sid_proc; PROC_WR && PROC_ADDR == 8'h2C && PROC_BE == 4'hF &&
    !EE_LOAD_BUSY && !EE_LOAD_DONE
    ##1 PROC_ADDR == 8'h2C |=> PROC_RDATA == $past(PROC_WDATA, 2); endproperty
  a_sid_proc: assert property (p_sid_proc) else $error("ident write lost");
  property p_misc_pci; PCI_WR && PCI_ADDR == 8'h3C && PROC_ADDR == 8'h3C && !PROC_WR &&
    !EE_LOAD_DONE ##1 PROC_ADDR == 8'h3C |=> $stable(PROC_RDATA[31:8]); endproperty
  a_misc_pci: assert property (p_misc_pci) else $error("latency word changed");
  property p_pin; PCI_ADDR == 8'h3C |=> PCI_RDATA[15:8] == {7'h00, $past(USES_INTA)};
  endproperty
  a_pin: assert property (p_pin) else $error("pin byte wrong");
  property p_rom_dis; !ROM_REG_ENABLED && PCI_ADDR == 8'h30 |=> PCI_RDATA == 32'h0;
  endproperty
  a_rom_dis: assert property (p_rom_dis) else $error("disabled rom nonzero");
  property p_rom_ro; PCI_ADDR == 8'h30 |=> (PCI_RDATA & $past(ro_mask)) == 32'h0;
  endproperty
  a_rom_ro: assert property (p_rom_ro) else $error("rom fixed bit set");
  property p_hit; ROM_HIT |-> ROM_REG_ENABLED; endproperty
  a_hit: assert property (p_hit) else $error("hit while disabled");
endmodule

// ### tb/pci_host_model.sv
// configuration host on the pci side of the bank
// assumes read data one cycle after the address
`timescale 1ns/1ps
module pci_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  output logic             wr,
  output logic [7:0]       addr,
  output logic [31:0]      wdata,
  output logic [3:0]       be);
  initial begin
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'h0;
  end
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    be = 4'hF;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;
    be = 4'h0;
  endtask
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

// ### tb/cfg_upper_regs_tb.sv
// self-checking bench for cfg_upper_regs
// assumes pci_host_model on pci side, checker bound at the foot
`timescale 1ns/1ps
module cfg_upper_regs_tb;
  logic        clk = 1'b0, rstn = 1'b0, strap = 1'b1, busy = 1'b0, done = 1'b0, pwr = 1'b0;
  logic        hwr, hit, rom_en, inta;
  logic        erom = 1'b1;
  logic [2:0]  bs = 3'h0;
  logic [3:0]  hbe;
  logic [7:0]  paddr = 8'h00, haddr;
  logic [31:0] pwd = 32'h0, prd, hwd, hrd, ad = 32'h0, rnd = 32'h24, ee = 32'h0;
  int          mismatches = 0, checks = 0;
  cfg_upper_regs i_cfg_upper_regs (.CLK(clk), .RSTN(rstn), .ID_LOAD_ENABLE_PIN(strap),
    .BLOCK_SIZE_FIELD(bs), .EE_LOAD_BUSY(busy), .EE_LOAD_DONE(done),
    .EE_SUBSYSTEM_IDENT(ee[31:16]), .EE_SUBSYSTEM_VENDOR_IDENT(ee[15:0]),
    .EE_ROM_ENABLE(erom), .EE_INT_PIN(ee[0]), .EE_MIN_GNT(ee[23:16]),
    .EE_MAX_LATENCY(ee[31:24]), .PCI_WR(hwr), .PCI_ADDR(haddr), .PCI_WDATA(hwd),
    .PCI_BE(hbe), .PCI_RDATA(hrd), .PROC_WR(pwr), .PROC_ADDR(paddr), .PROC_WDATA(pwd),
    .PROC_BE(4'hF), .PROC_RDATA(prd), .PCI_AD(ad), .ROM_HIT(hit),
    .ROM_REG_ENABLED(rom_en), .USES_INTA(inta));
  pci_host_model i_pci_host_model (.clk(clk), .rdata(hrd), .wr(hwr), .addr(haddr),
    .wdata(hwd), .be(hbe));
  always #4 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic pw(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    pwr = 1'b1;
    paddr = a;
    pwd = d;
    @(negedge clk);
    pwr = 1'b0;
    pwd = ~d;
  endtask
  task automatic pr(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    paddr = a;
    @(negedge clk);
    d = prd;
  endtask
  // ==========
  // reset with strap, then one eeprom load
  task automatic boot(input logic s);
    strap = s;
    rnd = lfsr(rnd);
    ee = rnd;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    end_sim;
  end
  initial begin
    logic [31:0] d;
    logic [31:0] m;
    boot(1'b1);
    pr(8'h2C, d);
    check(d, ee);
    check({31'h0, inta}, {31'h0, ee[0]});
    check({31'h0, rom_en}, 32'h1);
    i_pci_host_model.cfg_wr(8'h2C, ~ee);
    pr(8'h2C, d);
    check(d, ee);
    busy = 1'b1;
    pw(8'h2C, 32'h0);
    busy = 1'b0;
    pr(8'h2C, d);
    check(d, ee);
    rnd = lfsr(rnd);
    pw(8'h2C, rnd);
    pr(8'h2C, d);
    check(d, rnd);
    for (int n = 0; n < 8; n++) begin
      bs = n[2:0];
      m = 32'hFFFF_FFFF << (16 + n);
      i_pci_host_model.cfg_wr(8'h30, 32'hFFFF_FFFF);
      i_pci_host_model.cfg_rd(8'h30, d);
      check(d, m | 32'h1);
      ad = m;
      #1 check({31'h0, hit}, 32'h1);
      ad = ~m;
      #1 check({31'h0, hit}, 32'h0);
    end
    pw(8'h30, 32'h0);
    i_pci_host_model.cfg_rd(8'h30, d);
    check(d, 32'h0);
    busy = 1'b1;
    i_pci_host_model.cfg_wr(8'h30, 32'hFFFF_FFFF);
    busy = 1'b0;
    i_pci_host_model.cfg_rd(8'h30, d);
    check(d, 32'h0);
    i_pci_host_model.cfg_rd(8'h34, d);
    check(d, 32'h0000_00DC);
    pr(8'h3C, d);
    check(d, {ee[31:16], 7'h00, ee[0], 8'h00});
    i_pci_host_model.cfg_wr(8'h3C, 32'hFFFF_FFFF);
    pr(8'h3C, d);
    check(d, {ee[31:16], 7'h00, ee[0], 8'hFF});
    pw(8'h3C, 32'h0);
    pr(8'h3C, d);
    check({d[31:1], inta}, 32'h0);
    boot(1'b0);
    pr(8'h2C, d);
    check(d, 32'h0);
    check({31'h0, rom_en}, 32'h0);
    i_pci_host_model.cfg_wr(8'h30, 32'hFFFF_FFFF);
    i_pci_host_model.cfg_rd(8'h30, d);
    check(d, 32'h0);
    erom = 1'b0;
    boot(1'b1);
    check({31'h0, rom_en}, 32'h0);
    i_pci_host_model.cfg_wr(8'h30, 32'hFFFF_FFFF);
    i_pci_host_model.cfg_rd(8'h30, d);
    check(d, 32'h0);
    end_sim;
  end
endmodule
bind cfg_upper_regs cfg_upper_regs_sva i_cfg_upper_regs_sva (.CLK(CLK), .RSTN(RSTN),
  .PCI_WR(PCI_WR), .PROC_WR(PROC_WR), .EE_LOAD_BUSY(EE_LOAD_BUSY),
  .EE_LOAD_DONE(EE_LOAD_DONE), .ROM_HIT(ROM_HIT), .ROM_REG_ENABLED(ROM_REG_ENABLED),
  .USES_INTA(USES_INTA), .BLOCK_SIZE_FIELD(BLOCK_SIZE_FIELD), .PROC_BE(PROC_BE),
  .PCI_ADDR(PCI_ADDR),
  .PROC_ADDR(PROC_ADDR), .PCI_RDATA(PCI_RDATA), .PROC_RDATA(PROC_RDATA),
  .PROC_WDATA(PROC_WDATA));
